// *** plc_top.sv ***
// module: pll reference control with apb register access
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// What this block does
// - coarse loop first, then analog loop
// - counter up when reference is faster
// - coarse loop stops after 750 us
// - analog instability resets coarse loop
// - feedback divider gives 49.152 from 2.048
// - alignment on: outputs synced to input
// - alignment off: dividers synced to output
// - alignment default on except master role
// - slave roles and secondary master wait two frames after analog loop start
// - master: fast reference bypasses coarse loop
// - pcm frame start follows bus frame except in compat slave role
// - slave: slave clock feeds analog loop
// - compat mode: slow reference via digital loop
// - compat mode: oscillator or pcm clock direct
// - error checking starts at master/slave command
// - reset forces internal oscillator path
// - error: oscillator, config reset, flag
// - wrong source for role is an error
// - fallback switches only through multiplexers
// - analog bypassed until external frequency set
// - lock bit set once analog loop locks
// ****************************************
module plc_top
   import plc_pkg::*;
#(
   parameter int DLOOP_COUNT = DLOOP_CYCLES,
   parameter int FRAME_COUNT = FRAME_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   input  wire logic        ref_faster,
   input  wire logic        osc_faster,
   input  wire logic        analog_unstable,
   input  wire logic        analog_locked,
   input  wire logic        ref_ge_2048,
   input  wire logic        frame_aligned,
   input  wire logic        fallback_to_sec,
   output logic             digital_coarse_loop_en,
   output logic             analog_loop_en,
   output logic [9:0]       coarse_dac,
   output logic [7:0]       feedback_div,
   output logic [2:0]       analog_loop_src,
   output logic             dloop_bypass,
   output logic             phase_align_all,
   output logic             pcm_frame_follow,
   output logic             frame_sync_en,
   output logic             frame_synced,
   output logic             wrong_src_pulse
);
   // ****************************************
   // bus decode
   // ****************************************
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   logic       wr_cmd;
   logic       rd_stat;
   logic [3:0] opcode;
   assign pready  = 1'b1;
   assign wr_cmd  = psel && penable && pwrite && hit(paddr, ADDR_CONFIG_COMMAND_REG_ONE);
   assign rd_stat = psel && penable && !pwrite && hit(paddr, ADDR_INTERRUPT_STATUS_REG_ONE);
   assign opcode  = pwdata[CMD_OP_LSB +: 4];
   assign pslverr = psel && penable && !(hit(paddr, ADDR_CONFIG_COMMAND_REG_ONE) ||
                    hit(paddr, ADDR_INTERRUPT_STATUS_REG_ONE) || hit(paddr, ADDR_LOOP));

   // ****************************************
   // configuration
   // ****************************************
   plc_role_e  role_reg;
   plc_src_e   sel_src_reg;
   logic       ext_freq_set_reg;
   logic       cfg_done_reg;
   logic       align_reg;
   logic       cfg_error;

   function automatic logic role_is_slave(input plc_role_e r);
      role_is_slave = (r == PLC_ROLE_SLAVE) || (r == PLC_ROLE_COMPAT_SLV);
   endfunction

   function automatic logic role_is_master(input plc_role_e r);
      role_is_master = (r == PLC_ROLE_MASTER) || (r == PLC_ROLE_SEC_MASTER);
   endfunction

   assign cfg_error = cfg_done_reg &&
      ((role_is_master(role_reg) && sel_src_reg == PLC_SRC_SLAVE_PATH) ||
       (role_reg == PLC_ROLE_SLAVE &&
        (sel_src_reg == PLC_SRC_MAIN_REF || sel_src_reg == PLC_SRC_SEC_REF)));

   always_ff @(posedge ref_clk) begin
      if (rst || cfg_error) begin
         role_reg     <= PLC_ROLE_MASTER;
         sel_src_reg  <= PLC_SRC_INT_OSC;
         cfg_done_reg <= 1'b0;
         align_reg    <= 1'b0;
      end else if (wr_cmd) begin
         case (opcode)
            OP_REF_SELECT: begin
               sel_src_reg <= plc_src_e'(pwdata[2:0]);
            end
            OP_MASTER_SLAVE: begin
               role_reg     <= plc_role_e'(pwdata[6:4]);
               cfg_done_reg <= 1'b1;
               align_reg    <= (plc_role_e'(pwdata[6:4]) != PLC_ROLE_MASTER);
            end
            OP_PHASE_ALIGN: begin
               align_reg <= pwdata[0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ext_freq_set_reg <= 1'b0;
      end else if (wr_cmd && opcode == OP_SET_EXT_FREQ) begin
         ext_freq_set_reg <= 1'b1;
      end
   end

   // ****************************************
   // start-up sequence
   // ****************************************
   plc_state_e  state_reg;
   logic [31:0] dcnt_reg;
   logic        dloop_done;
   assign dloop_done = (dcnt_reg >= 32'(DLOOP_COUNT - 1));

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= PLC_ST_BYPASS;
      end else begin
         case (state_reg)
            PLC_ST_BYPASS: begin
               if (ext_freq_set_reg) begin
                  state_reg <= PLC_ST_COARSE;
               end
            end
            PLC_ST_COARSE: begin
               if (dloop_done) begin
                  state_reg <= PLC_ST_ANALOG;
               end
            end
            PLC_ST_ANALOG: begin
               if (analog_unstable) begin
                  state_reg <= PLC_ST_COARSE;
               end
            end
            default: begin
               state_reg <= PLC_ST_BYPASS;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || state_reg != PLC_ST_COARSE || dloop_done) begin
         dcnt_reg <= 32'h0;
      end else begin
         dcnt_reg <= dcnt_reg + 32'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || analog_unstable) begin
         coarse_dac <= DAC_RESET;
      end else if (state_reg == PLC_ST_COARSE) begin
         if (ref_faster && !osc_faster && coarse_dac != 10'h3FF) begin
            coarse_dac <= coarse_dac + 10'h1;
         end else if (osc_faster && !ref_faster && coarse_dac != 10'h000) begin
            coarse_dac <= coarse_dac - 10'h1;
         end
      end
   end

   assign digital_coarse_loop_en = (state_reg == PLC_ST_COARSE);
   assign analog_loop_en         = (state_reg == PLC_ST_ANALOG);

   // ****************************************
   // source multiplexing
   // ****************************************
   logic [2:0] src_next;
   always_comb begin
      src_next = PLC_SRC_INT_OSC;
      if (cfg_done_reg && !cfg_error) begin
         if (role_reg == PLC_ROLE_SLAVE) begin
            src_next = PLC_SRC_SLAVE_PATH;
         end else if (role_is_master(role_reg) && fallback_to_sec) begin
            src_next = PLC_SRC_SEC_REF;
         end else begin
            src_next = sel_src_reg;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         feedback_div     <= FB_DIVIDER;
         analog_loop_src  <= PLC_SRC_INT_OSC;
         dloop_bypass     <= 1'b1;
         phase_align_all  <= 1'b0;
         pcm_frame_follow <= 1'b0;
         wrong_src_pulse  <= 1'b0;
      end else begin
         feedback_div     <= FB_DIVIDER;
         analog_loop_src  <= src_next;
         dloop_bypass     <= ref_ge_2048 || role_reg == PLC_ROLE_SLAVE;
         phase_align_all  <= align_reg;
         pcm_frame_follow <= role_reg != PLC_ROLE_COMPAT_SLV;
         wrong_src_pulse  <= cfg_error;
      end
   end

   // ****************************************
   // frame synchronization
   // ****************************************
   logic [31:0] fcnt_reg;
   logic [1:0]  frames_reg;
   assign frame_sync_en = cfg_done_reg && analog_loop_en &&
      (role_is_slave(role_reg) || role_reg == PLC_ROLE_SEC_MASTER);

   always_ff @(posedge ref_clk) begin
      if (rst || !frame_sync_en) begin
         fcnt_reg     <= 32'h0;
         frames_reg   <= 2'h0;
         frame_synced <= 1'b0;
      end else if (frames_reg == 2'(SYNC_FRAMES)) begin
         frame_synced <= frame_aligned || frame_synced;
      end else if (fcnt_reg >= 32'(FRAME_COUNT - 1)) begin
         fcnt_reg   <= 32'h0;
         frames_reg <= frames_reg + 2'h1;
      end else begin
         fcnt_reg <= fcnt_reg + 32'h1;
      end
   end

   // ****************************************
   // status and read back
   // ****************************************
   logic lock_reg;
   logic wrong_reg;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lock_reg  <= 1'b0;
         wrong_reg <= 1'b0;
      end else begin
         // set wins over read clear
         lock_reg  <= (analog_loop_en && analog_locked) || (lock_reg && !rd_stat);
         wrong_reg <= cfg_error || (wrong_reg && !rd_stat);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         if (hit(paddr, ADDR_INTERRUPT_STATUS_REG_ONE)) begin
            prdata <= {28'h0, digital_coarse_loop_en, frame_synced,
                       wrong_reg || cfg_error, lock_reg};
         end else if (hit(paddr, ADDR_LOOP)) begin
            prdata <= {14'h0, state_reg, feedback_div, align_reg, role_reg, 1'b0,
                       analog_loop_src};
         end else begin
            prdata <= 32'h0;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_reset_osc_path: assert property (@(posedge ref_clk)
      rst |=> analog_loop_src == PLC_SRC_INT_OSC)
      else $error("loop source not oscillator after reset");
   a_error_cfg_clear: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_error |=> !cfg_done_reg && wrong_src_pulse && analog_loop_src == PLC_SRC_INT_OSC)
      else $error("config error not handled");
   a_coarse_hold: assert property (@(posedge ref_clk) disable iff (rst)
      !digital_coarse_loop_en && !analog_unstable |=> $stable(coarse_dac))
      else $error("coarse value moved outside coarse phase");
   a_count_up: assert property (@(posedge ref_clk) disable iff (rst)
      digital_coarse_loop_en && ref_faster && !osc_faster && !analog_unstable
      && coarse_dac != 10'h3FF |=> coarse_dac == $past(coarse_dac) + 10'h1)
      else $error("counter did not increment");
   a_count_down: assert property (@(posedge ref_clk) disable iff (rst)
      digital_coarse_loop_en && osc_faster && !ref_faster && !analog_unstable
      && coarse_dac != 10'h000 |=> coarse_dac == $past(coarse_dac) - 10'h1)
      else $error("counter did not decrement");
   a_unstable_reset: assert property (@(posedge ref_clk) disable iff (rst)
      analog_unstable |=> coarse_dac == DAC_RESET)
      else $error("instability did not reset coarse loop");
   a_loops_exclusive: assert property (@(posedge ref_clk) disable iff (rst)
      !(digital_coarse_loop_en && analog_loop_en))
      else $error("both loops enabled");
   a_divider_value: assert property (@(posedge ref_clk) disable iff (rst)
      feedback_div == 8'h18)
      else $error("feedback divider wrong");
   a_bypass_before: assert property (@(posedge ref_clk) disable iff (rst)
      !ext_freq_set_reg |-> !analog_loop_en && !digital_coarse_loop_en)
      else $error("analog loop active before frequency set");
   a_lock_needs_loop: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(lock_reg) |-> $past(analog_loop_en && analog_locked))
      else $error("lock bit set without lock");
   a_frame_wait: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(frame_synced) |-> frames_reg == 2'(SYNC_FRAMES))
      else $error("frame sync before two frames");
   a_slave_source: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_done_reg && !cfg_error && role_reg == PLC_ROLE_SLAVE
      |=> analog_loop_src == PLC_SRC_SLAVE_PATH)
      else $error("slave not fed from slave path");

   // ****************************************
   // step sequences
   // ****************************************
   sequence s_ext_freq_written;
      wr_cmd && opcode == OP_SET_EXT_FREQ && state_reg == PLC_ST_BYPASS;
   endsequence

   sequence s_coarse_begins;
      !digital_coarse_loop_en ##1 digital_coarse_loop_en;
   endsequence

   sequence s_bad_config;
      cfg_error;
   endsequence

   sequence s_config_cleared;
      !cfg_done_reg && wrong_reg ##1 !wrong_src_pulse;
   endsequence

   a_coarse_start: assert property (@(posedge ref_clk) disable iff (rst)
      s_ext_freq_written |=> s_coarse_begins)
      else $error("coarse loop did not start after frequency set");
   a_error_steps: assert property (@(posedge ref_clk) disable iff (rst)
      s_bad_config |=> s_config_cleared)
      else $error("config error steps wrong");
   a_coarse_stops: assert property (@(posedge ref_clk) disable iff (rst)
      digital_coarse_loop_en && dloop_done |=> analog_loop_en)
      else $error("coarse loop did not hand over");
   a_master_bypass: assert property (@(posedge ref_clk) disable iff (rst)
      role_is_master(role_reg) && ref_ge_2048 |=> dloop_bypass)
      else $error("fast reference not bypassed");
   a_slave_bypass: assert property (@(posedge ref_clk) disable iff (rst)
      role_reg == PLC_ROLE_SLAVE |=> dloop_bypass)
      else $error("slave role not bypassing digital loop");
   a_compat_slow_ref: assert property (@(posedge ref_clk) disable iff (rst)
      role_reg == PLC_ROLE_COMPAT_MST && !ref_ge_2048 |=> !dloop_bypass)
      else $error("slow reference skipped digital loop");
   a_lock_set: assert property (@(posedge ref_clk) disable iff (rst)
      analog_loop_en && analog_locked |=> lock_reg)
      else $error("lock bit not set");
   a_align_default: assert property (@(posedge ref_clk) disable iff (rst)
      wr_cmd && opcode == OP_MASTER_SLAVE && !cfg_error |=> align_reg == (role_reg != PLC_ROLE_MASTER))
      else $error("alignment default wrong for role");
endmodule
`default_nettype wire

// *** plc_pkg.sv ***
// package: constants and types of the pll reference control block
package plc_pkg;
   localparam int          CLK_MHZ             = 200;
   localparam int          DLOOP_TIME_US       = 750;
   localparam int          DLOOP_CYCLES        = DLOOP_TIME_US * CLK_MHZ;
   localparam int          FRAME_TIME_US       = 125;
   localparam int          FRAME_CYCLES        = FRAME_TIME_US * CLK_MHZ;
   localparam int          SYNC_FRAMES         = 2;
   localparam int          REF_KHZ_2048        = 2048;
   localparam int          OUT_KHZ             = 49152;
   localparam logic [7:0]  FB_DIVIDER          = 8'(OUT_KHZ / REF_KHZ_2048);
   localparam logic [9:0]  DAC_RESET           = 10'h200;
   // register byte addresses
   localparam logic [11:0] ADDR_CONFIG_COMMAND_REG_ONE           = 12'h000;
   localparam logic [11:0] ADDR_INTERRUPT_STATUS_REG_ONE          = 12'h004;
   localparam logic [11:0] ADDR_LOOP           = 12'h008;
   // command register one fields
   localparam int          CMD_OP_LSB          = 28;
   localparam logic [3:0]  OP_SET_EXT_FREQ     = 4'h1;
   localparam logic [3:0]  OP_REF_SELECT       = 4'h2;
   localparam logic [3:0]  OP_MASTER_SLAVE     = 4'h3;
   localparam logic [3:0]  OP_PHASE_ALIGN      = 4'h4;
   // status bit positions
   localparam int          ST_LOCK             = 0;
   localparam int          ST_WRONG_SRC        = 1;
   localparam int          ST_FRAME_SYNC       = 2;
   localparam int          ST_DLOOP_ON         = 3;
   // roles
   typedef enum logic [2:0] {
      PLC_ROLE_MASTER     = 3'h0,
      PLC_ROLE_SEC_MASTER = 3'h1,
      PLC_ROLE_SLAVE      = 3'h3,
      PLC_ROLE_COMPAT_MST = 3'h2,
      PLC_ROLE_COMPAT_SLV = 3'h6
   } plc_role_e;
   // analog loop input sources
   typedef enum logic [2:0] {
      PLC_SRC_INT_OSC     = 3'h0,
      PLC_SRC_MAIN_REF    = 3'h1,
      PLC_SRC_SEC_REF     = 3'h2,
      PLC_SRC_SLAVE_PATH  = 3'h3,
      PLC_SRC_PCM_CLK     = 3'h4
   } plc_src_e;
   // start-up sequence, gray coded
   typedef enum logic [1:0] {
      PLC_ST_BYPASS  = 2'b00,
      PLC_ST_COARSE  = 2'b01,
      PLC_ST_ANALOG  = 2'b11
   } plc_state_e;
endpackage

// *** plc_far_model.sv ***
// far side model: frequency detector, analog loop lock and frame comparator
`timescale 1ns/1ps
`default_nettype none
module plc_far_model (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [9:0] coarse_dac,
   input  wire logic [9:0] target,
   input  wire logic       analog_loop_en,
   output logic            ref_faster,
   output logic            osc_faster,
   output logic            analog_locked,
   output logic            frame_aligned
);
   logic [3:0] lock_cnt;
   // ****************************************
   // detector: dac below target means oscillator slow
   // ****************************************
   assign ref_faster = coarse_dac < target;
   assign osc_faster = coarse_dac > target;
   always_ff @(posedge ref_clk) begin
      if (rst || !analog_loop_en) begin
         lock_cnt <= 4'h0;
      end else if (lock_cnt != 4'hF) begin
         lock_cnt <= lock_cnt + 4'h1;
      end
   end
   assign analog_locked = lock_cnt == 4'hF;
   assign frame_aligned = analog_locked;
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking testbench of the pll reference control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_fail++; \
 $display("Error %s exp %h got %h", nm, ex, gt); end end
module tb;
   import plc_pkg::*;
   localparam int FC = 10;
   logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er, ref_faster, osc_faster, analog_locked, frame_aligned;
   logic        analog_unstable = 0, ref_ge_2048 = 0, fallback_to_sec = 0;
   logic        cl_en, an_en, dloop_bypass, pa_all, pcm_ff, fs_en, frame_synced, wsp;
   logic [9:0]  coarse_dac, target = 10'h208;
   logic [7:0]  feedback_div;
   logic [2:0]  src;
   int          n_fail = 0, check_count = 0, cyc = 0, n_pulse = 0;
   always #2.5 ref_clk = ~ref_clk;
   plc_top #(.DLOOP_COUNT(20), .FRAME_COUNT(FC)) dut_u (.ref_clk(ref_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .ref_faster(ref_faster),
      .osc_faster(osc_faster), .analog_unstable(analog_unstable),
      .analog_locked(analog_locked), .ref_ge_2048(ref_ge_2048),
      .frame_aligned(frame_aligned), .fallback_to_sec(fallback_to_sec),
      .digital_coarse_loop_en(cl_en), .analog_loop_en(an_en), .coarse_dac(coarse_dac),
      .feedback_div(feedback_div), .analog_loop_src(src), .dloop_bypass(dloop_bypass),
      .phase_align_all(pa_all), .pcm_frame_follow(pcm_ff), .frame_sync_en(fs_en),
      .frame_synced(frame_synced), .wrong_src_pulse(wsp));
   plc_far_model far_u (.ref_clk(ref_clk), .rst(rst), .coarse_dac(coarse_dac),
      .target(target), .analog_loop_en(an_en), .ref_faster(ref_faster),
      .osc_faster(osc_faster), .analog_locked(analog_locked), .frame_aligned(frame_aligned));
   always @(posedge ref_clk) begin
      cyc++;
      if (wsp === 1'b1) n_pulse++;
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic final_report;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmd(input logic [3:0] op, input logic [27:0] arg);
      apb(1'b1, ADDR_CONFIG_COMMAND_REG_ONE, {op, arg});
   endtask
   task automatic wait_an;
      for (int i = 0; i < 200 && an_en !== 1'b1; i++) @(posedge ref_clk);
   endtask
   task automatic t_startup;
      `CHK("src", 3'h0, src)
      `CHK("dac", 10'h200, coarse_dac)
      `CHK("div", 8'h18, feedback_div)
      `CHK("analog_en", 1'b0, an_en)
      cmd(OP_SET_EXT_FREQ, 28'h0);
      repeat (2) @(posedge ref_clk);
      `CHK("coarse_en", 1'b1, cl_en)
      wait_an();
      `CHK("dac up", 10'h208, coarse_dac)
      `CHK("coarse_off", 1'b0, cl_en)
      target <= 10'h1F0;
      repeat (5) @(posedge ref_clk);
      `CHK("dac held", 10'h208, coarse_dac)
      analog_unstable <= 1'b1;
      @(posedge ref_clk);
      analog_unstable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      `CHK("relaunch", 1'b1, cl_en)
      wait_an();
      `CHK("dac down", 10'h1F0, coarse_dac)
      repeat (20) @(posedge ref_clk);
      apb(1'b0, ADDR_INTERRUPT_STATUS_REG_ONE, 32'h0);
      `CHK("lock bit", 1'b1, rd[ST_LOCK])
      $display("test startup done");
   endtask
   task automatic t_errors;
      cmd(OP_REF_SELECT, 28'h3);
      apb(1'b0, ADDR_INTERRUPT_STATUS_REG_ONE, 32'h0);
      `CHK("no check yet", 1'b0, rd[ST_WRONG_SRC])
      `CHK("src held", 3'h0, src)
      `CHK("no pulse", 0, n_pulse)
      cmd(OP_MASTER_SLAVE, 28'h00);
      repeat (3) @(posedge ref_clk);
      `CHK("pulses", 1, n_pulse)
      `CHK("src osc", 3'h0, src)
      apb(1'b0, ADDR_INTERRUPT_STATUS_REG_ONE, 32'h0);
      `CHK("wrong bit", 1'b1, rd[ST_WRONG_SRC])
      $display("test errors done");
   endtask
   task automatic t_slave;
      int n;
      cmd(OP_REF_SELECT, 28'h3);
      cmd(OP_MASTER_SLAVE, 28'h30);
      repeat (2) @(posedge ref_clk);
      `CHK("pulses", 1, n_pulse)
      `CHK("align", 1'b1, pa_all)
      `CHK("slave src", 3'h3, src)
      `CHK("not synced", 1'b0, frame_synced)
      `CHK("sync enabled", 1'b1, fs_en)
      for (n = 0; n < 80 && frame_synced !== 1'b1; n++) @(posedge ref_clk);
      `CHK("synced", 1'b1, frame_synced)
      `CHK("two frames", 1'b1, n >= 2 * FC - 1)
      cmd(OP_REF_SELECT, 28'h1);
      repeat (3) @(posedge ref_clk);
      `CHK("pulses", 2, n_pulse)
      $display("test slave done");
   endtask
   task automatic t_master;
      cmd(OP_REF_SELECT, 28'h1);
      cmd(OP_MASTER_SLAVE, 28'h00);
      repeat (2) @(posedge ref_clk);
      `CHK("pulses", 2, n_pulse)
      `CHK("align", 1'b0, pa_all)
      `CHK("main src", 3'h1, src)
      `CHK("pcm follow", 1'b1, pcm_ff)
      fallback_to_sec <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK("fallback src", 3'h2, src)
      fallback_to_sec <= 1'b0;
      repeat (2) @(posedge ref_clk);
      `CHK("main again", 3'h1, src)
      cmd(OP_PHASE_ALIGN, 28'h1);
      repeat (2) @(posedge ref_clk);
      `CHK("align on", 1'b1, pa_all)
      ref_ge_2048 <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK("bypass", 1'b1, dloop_bypass)
      ref_ge_2048 <= 1'b0;
      cmd(OP_PHASE_ALIGN, 28'h0);
      repeat (2) @(posedge ref_clk);
      `CHK("no bypass", 1'b0, dloop_bypass)
      `CHK("align off", 1'b0, pa_all)
      apb(1'b0, 12'h0FC, 32'h0);
      `CHK("slverr", 1'b1, er)
      `CHK("rdata", 32'h0, rd)
      cmd(OP_MASTER_SLAVE, 28'h20);
      cmd(OP_REF_SELECT, 28'h4);
      repeat (2) @(posedge ref_clk);
      `CHK("pcm clk src", 3'h4, src)
      `CHK("compat no bypass", 1'b0, dloop_bypass)
      `CHK("pulses", 2, n_pulse)
      $display("test master done");
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      t_startup();
      t_errors();
      t_slave();
      t_master();
      final_report();
   end
endmodule
`default_nettype wire
